/* shared/pport_pkg.sv */
// shared constants, types and configuration layout for the parallel port
package pport_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // pulse and filter times in ns, as printed
    localparam int ACK_NARROW_NS = 500;
    localparam int ACK_MEDIUM_NS = 1000;
    localparam int ACK_WIDE_NS = 3000;
    localparam int INIT_SHORT_NS = 3000;
    localparam int INIT_LONG_NS = 50000;
    // least times round up to whole cycles
    localparam int ACK_NARROW_CYC =
        (ACK_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_MEDIUM_CYC =
        (ACK_MEDIUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_WIDE_CYC =
        (ACK_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_SHORT_CYC =
        (INIT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_LONG_CYC =
        (INIT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    // extensibility bytes seen during negotiation
    localparam logic [7:0] XREQ_NIBBLE = 8'h00;
    localparam logic [7:0] XREQ_ECP = 8'h10;

    typedef enum logic [1:0] {ACK_NARROW, ACK_MEDIUM, ACK_WIDE} ack_width_t;
    typedef enum logic [1:0] {INIT_OFF, INIT_SHORT, INIT_LONG} init_filt_t;
    typedef enum logic [1:0] {MODE_COMPAT, MODE_NIBBLE, MODE_ECP} xfer_mode_t;

    typedef struct packed {
        logic if_en;
        logic bidir;
        logic ecp_en;
        ack_width_t ack_width;
        logic busy_while;
        init_filt_t init_filt;
        logic offline_rx;
    } pport_cfg_t;

    localparam pport_cfg_t CFG_DEFAULT = '{
        if_en: 1'b1, bidir: 1'b1, ecp_en: 1'b1, ack_width: ACK_NARROW,
        busy_while: 1'b0, init_filt: INIT_OFF, offline_rx: 1'b0};

    // host-driven pins, all active as on the cable
    typedef struct packed {
        logic strobe_n;
        logic init_n;
        logic selin_n;
        logic autofd_n;
        logic [7:0] data;
    } host_pins_t;

    // printer condition fed in by firmware
    typedef struct packed {
        logic online;
        logic paper_out;
        logic alarm;
    } prn_status_t;
endpackage

/* rtl/pport_rx.sv */
// printer side of the byte-wide parallel host port
// Behaviour
// R1 - capture data byte on strobe, hand to buffer
// R2 - busy while processing or alarm; ack pulses
// R3 - fault on paper out or alarm
// R4 - compatibility, nibble and ECP modes supported
// R5 - forward-only setting blocks reverse data
// R6 - ack width narrow, medium or wide
// R7 - busy released at end or centre of ack
// R8 - short init filter needs 3us low
// R9 - long filter 50us; disabled ignores init
// R10 - offline receive setting gates reception
// R11 - settings come from non-volatile store
// R12 - interface and ECP enables, default enabled
module pport_rx
    import pport_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // host pins
    input wire host_pins_t host_i,
    // printer status and stored settings
    input wire prn_status_t status_i,
    input wire pport_cfg_t nvm_cfg_i,
    input wire logic nvm_load_i,
    // received bytes towards the receive buffer
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic rx_ready_i,
    // reverse bytes from the printer
    input wire logic rev_valid_i,
    input wire logic [7:0] rev_data_i,
    output logic rev_ready_o,
    // printer pins
    output logic ack_n_o,
    output logic busy_o,
    output logic paper_end_o,
    output logic select_o,
    output logic fault_n_o,
    output logic [3:0] rev_nibble_o,
    // status to firmware
    output logic init_req_o,
    output xfer_mode_t mode_o
);
    typedef enum logic [2:0] {S_IDLE, S_HAND, S_ACK, S_REV_ACK} fsm_t;

    typedef struct packed {
        host_pins_t sync1;
        host_pins_t sync2;
        host_pins_t prev;
        fsm_t fsm;
        logic [CNT_W-1:0] ack_cnt;
        logic [CNT_W-1:0] init_cnt;
        logic init_done;
        logic [7:0] byte_q;
        logic rx_valid;
        logic [3:0] nibble;
        logic hi_half;
        logic rev_take;
        logic init_req;
        logic cfg_loaded;
        pport_cfg_t cfg;
        xfer_mode_t mode;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic [CNT_W-1:0] ack_cycles(ack_width_t w);
        unique case (w)
            ACK_MEDIUM: ack_cycles = CNT_W'(ACK_MEDIUM_CYC);
            ACK_WIDE: ack_cycles = CNT_W'(ACK_WIDE_CYC);
            default: ack_cycles = CNT_W'(ACK_NARROW_CYC);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] init_cycles(init_filt_t f);
        init_cycles = (f == INIT_LONG) ? CNT_W'(INIT_LONG_CYC)
                                       : CNT_W'(INIT_SHORT_CYC);
    endfunction

    logic stb_fell;
    logic accept_ok;
    logic rev_req;
    logic [CNT_W-1:0] ack_len;

    // ****************************************************************
    // combinational next state
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = host_i;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        s_next.init_req = 1'b0;
        s_next.rev_take = 1'b0;
        ack_len = ack_cycles(s_reg.cfg.ack_width);
        stb_fell = s_reg.prev.strobe_n && !s_reg.sync2.strobe_n;
        // offline bytes are held off by busy; a strobe sent anyway is ignored, not queued
        accept_ok = s_reg.cfg.if_en && !status_i.alarm   // [R12] [R2]
            && (status_i.online || s_reg.cfg.offline_rx); // [R10]
        rev_req = s_reg.mode != MODE_COMPAT && s_reg.cfg.bidir // [R5]
            && !s_reg.sync2.autofd_n && s_reg.prev.autofd_n;

        // settings are reapplied from the store after every reset
        if (!s_reg.cfg_loaded || nvm_load_i) begin
            s_next.cfg = nvm_cfg_i; // [R11]
            s_next.cfg_loaded = 1'b1;
        end

        // negotiation: select-in rising latches the extensibility byte
        if (s_reg.sync2.selin_n && !s_reg.prev.selin_n
                && s_reg.fsm == S_IDLE) begin
            if (s_reg.sync2.data == XREQ_ECP && s_reg.cfg.ecp_en
                    && s_reg.cfg.bidir) begin
                s_next.mode = MODE_ECP; // [R12] [R4]
            end else if (s_reg.sync2.data == XREQ_NIBBLE
                    && s_reg.cfg.bidir) begin
                s_next.mode = MODE_NIBBLE; // [R4] [R5]
            end else begin
                s_next.mode = MODE_COMPAT;
            end
        end else if (!s_reg.sync2.selin_n) begin
            s_next.mode = MODE_COMPAT; // [R4]
        end

        if (s_reg.rx_valid && rx_ready_i) begin
            s_next.rx_valid = 1'b0;
        end

        unique case (s_reg.fsm)
            S_IDLE: begin
                if (stb_fell && accept_ok
                        && s_reg.mode != MODE_NIBBLE) begin
                    s_next.byte_q = s_reg.sync2.data; // [R1]
                    s_next.rx_valid = 1'b1;
                    s_next.fsm = S_HAND;
                end else if (rev_req && rev_valid_i) begin
                    s_next.nibble = s_reg.hi_half ? rev_data_i[7:4]
                                                  : rev_data_i[3:0];
                    s_next.ack_cnt = ack_len;
                    s_next.fsm = S_REV_ACK;
                end
            end
            S_HAND: begin
                // ack only once the buffer has taken the byte
                if (!s_reg.rx_valid) begin
                    s_next.ack_cnt = ack_len; // [R6]
                    s_next.fsm = S_ACK;
                end
            end
            S_ACK: begin
                s_next.ack_cnt = s_reg.ack_cnt - 1'b1;
                if (s_reg.ack_cnt == CNT_W'(1)) begin
                    s_next.fsm = S_IDLE; // [R6]
                end
            end
            S_REV_ACK: begin
                s_next.ack_cnt = s_reg.ack_cnt - 1'b1;
                if (s_reg.ack_cnt == CNT_W'(1)) begin
                    s_next.fsm = S_IDLE;
                    s_next.hi_half = !s_reg.hi_half;
                    s_next.rev_take = s_reg.hi_half;
                end
            end
            default: s_next.fsm = S_IDLE;
        endcase

        // init filter: one request per low period once held long enough
        if (s_reg.sync2.init_n || s_reg.cfg.init_filt == INIT_OFF) begin
            s_next.init_cnt = '0; // [R9]
            s_next.init_done = 1'b0;
        end else if (!s_reg.init_done) begin
            s_next.init_cnt = s_reg.init_cnt + 1'b1;
            if (s_reg.init_cnt + 1'b1
                    >= init_cycles(s_reg.cfg.init_filt)) begin
                s_next.init_req = 1'b1; // [R8] [R9]
                s_next.init_done = 1'b1;
                s_next.fsm = S_IDLE;
                s_next.mode = MODE_COMPAT;
                s_next.hi_half = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_reg <= '{sync1: '1, sync2: '1, prev: '1, fsm: S_IDLE,
                cfg: CFG_DEFAULT, mode: MODE_COMPAT, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    logic busy_hand;
    always_comb begin
        unique case (s_reg.fsm)
            S_IDLE: busy_hand = 1'b0;
            S_HAND: busy_hand = 1'b1;
            // while option drops busy at the centre of the pulse
            S_ACK: busy_hand = !s_reg.cfg.busy_while   // [R7]
                || s_reg.ack_cnt > (ack_len >> 1);
            default: busy_hand = 1'b1;
        endcase
    end

    assign busy_o = busy_hand || !accept_ok; // [R2] [R12]
    assign ack_n_o = !(s_reg.fsm == S_ACK || s_reg.fsm == S_REV_ACK);
    assign fault_n_o = !(status_i.paper_out || status_i.alarm); // [R3]
    assign paper_end_o = status_i.paper_out;
    assign select_o = status_i.online;
    assign rx_valid_o = s_reg.rx_valid;
    assign rx_data_o = s_reg.byte_q;
    assign rev_nibble_o = s_reg.nibble;
    assign rev_ready_o = s_reg.rev_take;
    assign init_req_o = s_reg.init_req;
    assign mode_o = s_reg.mode;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [CNT_W-1:0] low_cnt;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || ack_n_o) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    sequence take_byte_s;
        s_reg.fsm == S_IDLE && stb_fell && accept_ok
            && s_reg.mode != MODE_NIBBLE;
    endsequence
    sequence held_busy_s;
        busy_o && ack_n_o;
    endsequence

    byte_capture_a: assert property ( // [R1]
        @(posedge clk_i) disable iff (sys_rst_i)
        take_byte_s |=> rx_valid_o && rx_data_o == $past(s_reg.sync2.data))
        else $error("byte not captured on strobe");
    busy_on_take_a: assert property ( // [R2]
        @(posedge clk_i) disable iff (sys_rst_i)
        take_byte_s |=> held_busy_s)
        else $error("busy not raised after strobe");
    ack_width_a: assert property ( // [R6]
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(ack_n_o) && !$past(sys_rst_i) |->
            $past(low_cnt) + 1'b1 == ack_cycles(s_reg.cfg.ack_width))
        else $error("ack pulse width wrong");
    busy_in_order_a: assert property ( // [R7]
        @(posedge clk_i) disable iff (sys_rst_i)
        $fell(busy_o) && !s_reg.cfg.busy_while && accept_ok
            && $past(s_reg.fsm) == S_ACK |-> $rose(ack_n_o))
        else $error("busy released before end of ack");
    busy_while_a: assert property ( // [R7]
        @(posedge clk_i) disable iff (sys_rst_i)
        s_reg.fsm == S_ACK && s_reg.cfg.busy_while && accept_ok
            && s_reg.ack_cnt <= (ack_len >> 1) |-> !busy_o && !ack_n_o)
        else $error("busy not released at ack centre");
    fault_line_a: assert property ( // [R3]
        @(posedge clk_i) disable iff (sys_rst_i)
        fault_n_o == !(status_i.paper_out || status_i.alarm))
        else $error("fault line wrong");
    init_filter_a: assert property ( // [R8]
        @(posedge clk_i) disable iff (sys_rst_i)
        init_req_o |-> $past(s_reg.cfg.init_filt) != INIT_OFF
            && $past(s_reg.init_cnt) + 1'b1
               >= init_cycles($past(s_reg.cfg.init_filt)))
        else $error("init accepted too early");
    ecp_refuse_a: assert property ( // [R12]
        @(posedge clk_i) disable iff (sys_rst_i)
        $changed(mode_o) && mode_o == MODE_ECP |-> $past(s_reg.cfg.ecp_en))
        else $error("ecp entered while disabled");
    fwd_only_a: assert property ( // [R5]
        @(posedge clk_i) disable iff (sys_rst_i)
        s_reg.fsm == S_REV_ACK |-> s_reg.cfg.bidir)
        else $error("reverse data while forward-only");
    offline_hold_a: assert property ( // [R10]
        @(posedge clk_i) disable iff (sys_rst_i)
        !status_i.online && !s_reg.cfg.offline_rx |-> busy_o)
        else $error("reception while offline");
endmodule

/* tb/pport_host_model.sv */
// host side model of the parallel port: strobed bytes and negotiation
module pport_host_model
    import pport_pkg::*;
(
    // clock
    input wire logic clk_i,
    // pins towards the printer
    output host_pins_t host_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // host pin driver
    // ****************************************
    host_pins_t pins = '{strobe_n: 1'b1, init_n: 1'b1, selin_n: 1'b0,
                         autofd_n: 1'b1, data: 8'h00};
    assign host_o = pins;

    task automatic send_byte(input logic [7:0] b);
        @(negedge clk_i);
        pins.data = b;
        @(negedge clk_i);
        pins.strobe_n = 1'b0;
        repeat (3) @(negedge clk_i);
        pins.strobe_n = 1'b1;
        repeat (2) @(negedge clk_i);
        // hold time over: stale lines show a changed pattern, not the byte
        pins.data = ~b;
    endtask

    task automatic negotiate(input logic [7:0] x);
        @(negedge clk_i);
        pins.data = x;
        @(negedge clk_i);
        pins.selin_n = 1'b1;
        repeat (3) @(negedge clk_i);
        pins.data = ~x;
    endtask

    // level changes of the control lines, made at a falling clock edge
    task automatic set_init(input logic v);
        pins.init_n = v;
    endtask

    task automatic set_selin(input logic v);
        pins.selin_n = v;
    endtask

    // a falling edge here asks for the next reverse nibble
    task automatic set_autofd(input logic v);
        pins.autofd_n = v;
    endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the parallel port receiver
module tb_top
    import pport_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, e) begin \
    num_checks++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("Error at %0t: got %0h want %0h", $time, a, e); \
    end \
end

    // ****************************************
    // stimulus and instances
    // ****************************************
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    host_pins_t host;
    prn_status_t status = '{online: 1'b1, paper_out: 1'b0, alarm: 1'b0};
    pport_cfg_t nvm_cfg;
    logic nvm_load = 1'b0;
    logic rx_ready = 1'b0;
    logic rev_valid = 1'b0;
    logic [7:0] rev_data = 8'h00;
    logic rev_ready_o;
    logic [3:0] rev_nibble_o;
    logic rx_valid_o, ack_n_o, busy_o, paper_end_o, select_o, fault_n_o;
    logic init_req_o;
    logic [7:0] rx_data_o;
    xfer_mode_t mode_o;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc[3] = '{ACK_NARROW_CYC, ACK_MEDIUM_CYC, ACK_WIDE_CYC};

    always #10 clk_i = ~clk_i;

    pport_host_model host_m (.clk_i(clk_i), .host_o(host));

    pport_rx DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_i(host),
        .status_i(status), .nvm_cfg_i(nvm_cfg), .nvm_load_i(nvm_load),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
        .rx_ready_i(rx_ready), .rev_valid_i(rev_valid),
        .rev_data_i(rev_data),
        .rev_ready_o(rev_ready_o), .ack_n_o(ack_n_o), .busy_o(busy_o),
        .paper_end_o(paper_end_o), .select_o(select_o),
        .fault_n_o(fault_n_o), .rev_nibble_o(rev_nibble_o),
        .init_req_o(init_req_o),
        .mode_o(mode_o));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic timed_out();
        n_mismatch++;
        $display("Error at %0t: wait ran out", $time);
        tally_and_finish();
    endtask

    task automatic load_cfg(input pport_cfg_t c);
        @(negedge clk_i);
        nvm_cfg = c;
        nvm_load = 1'b1;
        @(negedge clk_i);
        nvm_load = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask

    // one accepted byte: data, buffer handshake, ack width, busy release
    task automatic run_byte(input logic [7:0] b, input int w, input logic wh);
        int i;
        int n;
        int lo;
        n = 0;
        lo = 0;
        `CHK(busy_o, 1'b0)
        host_m.send_byte(b);
        for (i = 0; i < 20 && rx_valid_o !== 1'b1; i++) @(negedge clk_i);
        if (rx_valid_o !== 1'b1) timed_out();
        `CHK(rx_data_o, b)
        `CHK(busy_o, 1'b1)
        rx_ready = 1'b1;
        @(negedge clk_i);
        rx_ready = 1'b0;
        for (i = 0; i < 400 && !(n > 0 && ack_n_o === 1'b1); i++) begin
            @(negedge clk_i);
            n += (ack_n_o === 1'b0);
            lo += (ack_n_o === 1'b0 && busy_o === 1'b0);
        end
        if (!(n > 0 && ack_n_o === 1'b1)) timed_out();
        `CHK(n, w)
        `CHK(lo > 0 && lo < w, wh)
        `CHK(busy_o, 1'b0)
    endtask

    task automatic refused(input logic [7:0] b);
        host_m.send_byte(b);
        repeat (10) @(negedge clk_i);
        `CHK(rx_valid_o, 1'b0)
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_widths();
        pport_cfg_t c;
        for (int k = 0; k < 6; k++) begin
            c = CFG_DEFAULT;
            c.ack_width = ack_width_t'(k % 3);
            c.busy_while = (k >= 3);
            load_cfg(c);
            run_byte(8'h5A ^ 8'(k), cyc[k % 3], k >= 3);
        end
        $display("ack width test done");
    endtask

    task automatic test_status();
        status = '{online: 1'b0, paper_out: 1'b1, alarm: 1'b0};
        @(negedge clk_i);
        `CHK(fault_n_o, 1'b0)
        `CHK(paper_end_o, 1'b1)
        `CHK(select_o, 1'b0)
        status = '{online: 1'b1, paper_out: 1'b0, alarm: 1'b1};
        @(negedge clk_i);
        `CHK(fault_n_o, 1'b0)
        `CHK(busy_o, 1'b1)
        status = '{online: 1'b1, paper_out: 1'b0, alarm: 1'b0};
        @(negedge clk_i);
        `CHK(fault_n_o, 1'b1)
        `CHK(select_o, 1'b1)
        $display("status test done");
    endtask

    task automatic test_gates();
        pport_cfg_t c;
        status.online = 1'b0;
        load_cfg(CFG_DEFAULT);
        `CHK(busy_o, 1'b1)
        refused(8'h11);
        c = CFG_DEFAULT;
        c.offline_rx = 1'b1;
        load_cfg(c);
        run_byte(8'h22, ACK_NARROW_CYC, 1'b0);
        status.online = 1'b1;
        c = CFG_DEFAULT;
        c.if_en = 1'b0;
        load_cfg(c);
        `CHK(busy_o, 1'b1)
        refused(8'h33);
        load_cfg(CFG_DEFAULT);
        $display("gate test done");
    endtask

    task automatic init_case(input init_filt_t f, input int len, input int e);
        pport_cfg_t c;
        int n;
        c = CFG_DEFAULT;
        c.init_filt = f;
        load_cfg(c);
        n = 0;
        host_m.set_init(1'b0);
        repeat (len) begin
            @(negedge clk_i);
            n += (init_req_o === 1'b1);
        end
        host_m.set_init(1'b1);
        repeat (6) begin
            @(negedge clk_i);
            n += (init_req_o === 1'b1);
        end
        `CHK(n, e)
    endtask

    task automatic neg_case(input logic bd, input logic ecp,
                            input logic [7:0] x, input xfer_mode_t m);
        pport_cfg_t c;
        c = CFG_DEFAULT;
        c.bidir = bd;
        c.ecp_en = ecp;
        load_cfg(c);
        host_m.negotiate(x);
        repeat (5) @(negedge clk_i);
        `CHK(mode_o, m)
        host_m.set_selin(1'b0);
        repeat (5) @(negedge clk_i);
        `CHK(mode_o, MODE_COMPAT)
    endtask

    // one reverse nibble: ack width, nibble shown, ready after high half
    task automatic rev_nibble(input logic [3:0] e, input int r);
        int i;
        int n;
        int rdy;
        logic [3:0] nib;
        n = 0;
        rdy = 0;
        nib = 4'h0;
        host_m.set_autofd(1'b0);
        for (i = 0; i < 400 && !(n > 0 && ack_n_o === 1'b1); i++) begin
            @(negedge clk_i);
            if (ack_n_o === 1'b0) begin
                n++;
                nib = rev_nibble_o;
            end
            rdy += (rev_ready_o === 1'b1);
        end
        host_m.set_autofd(1'b1);
        if (!(n > 0 && ack_n_o === 1'b1)) timed_out();
        `CHK(n, ACK_NARROW_CYC)
        `CHK(nib, e)
        `CHK(rdy, r)
        repeat (4) @(negedge clk_i);
    endtask

    task automatic test_reverse();
        pport_cfg_t c;
        int n;
        load_cfg(CFG_DEFAULT);
        host_m.negotiate(XREQ_NIBBLE);
        repeat (5) @(negedge clk_i);
        `CHK(mode_o, MODE_NIBBLE)
        rev_data = 8'hC3;
        rev_valid = 1'b1;
        rev_nibble(4'h3, 0);
        rev_nibble(4'hC, 1);
        // forward-only: a request in nibble mode must get no answer
        c = CFG_DEFAULT;
        c.bidir = 1'b0;
        load_cfg(c);
        n = 0;
        host_m.set_autofd(1'b0);
        repeat (10) begin
            @(negedge clk_i);
            n += (ack_n_o === 1'b0 || rev_ready_o === 1'b1);
        end
        host_m.set_autofd(1'b1);
        `CHK(n, 0)
        rev_valid = 1'b0;
        host_m.set_selin(1'b0);
        load_cfg(CFG_DEFAULT);
        $display("reverse test done");
    endtask

    // a reset in mid-run brings the stored settings back unprompted
    task automatic test_reset();
        nvm_cfg = CFG_DEFAULT;
        nvm_cfg.ack_width = ACK_WIDE;
        nvm_cfg.busy_while = 1'b1;
        sys_rst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        `CHK(ack_n_o, 1'b1)
        `CHK(rx_valid_o, 1'b0)
        sys_rst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        `CHK(mode_o, MODE_COMPAT)
        run_byte(8'h3C, ACK_WIDE_CYC, 1'b1);
        $display("reset test done");
    endtask

    initial begin
        nvm_cfg = CFG_DEFAULT;
        nvm_cfg.ack_width = ACK_MEDIUM;
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        `CHK(ack_n_o, 1'b1)
        `CHK(mode_o, MODE_COMPAT)
        // stored setting applies at power-up with no reload pulse
        run_byte(8'hA5, ACK_MEDIUM_CYC, 1'b0);
        $display("power-up test done");
        test_widths();
        test_status();
        test_gates();
        init_case(INIT_SHORT, 140, 0);
        init_case(INIT_SHORT, 160, 1);
        init_case(INIT_LONG, 2400, 0);
        init_case(INIT_LONG, 2600, 1);
        init_case(INIT_OFF, 2600, 0);
        $display("init filter test done");
        neg_case(1'b1, 1'b1, XREQ_NIBBLE, MODE_NIBBLE);
        neg_case(1'b0, 1'b1, XREQ_NIBBLE, MODE_COMPAT);
        neg_case(1'b1, 1'b1, XREQ_ECP, MODE_ECP);
        neg_case(1'b1, 1'b0, XREQ_ECP, MODE_COMPAT);
        neg_case(1'b0, 1'b1, XREQ_ECP, MODE_COMPAT);
        $display("negotiation test done");
        test_reverse();
        test_reset();
        tally_and_finish();
    end
endmodule
